// ### src/mt_pkg.sv
// Package for the modulo timer: register offsets, field positions, reset values.
// Assumes a 32-bit APB slave with one register per aligned word.
package mt_pkg;
  // ==========================================================================
  // Register byte addresses
  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CLOCK_CONFIG   = 4'h4;
  localparam logic [3:0] OFS_COUNT_VALUE    = 4'h8;
  localparam logic [3:0] OFS_WRAP_LIMIT     = 4'hc;
  // ==========================================================================
  // Field positions
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_IRQ_ENABLE    = 6;
  localparam int BIT_COUNTER_RESET = 5;
  localparam int BIT_COUNTER_HALT  = 4;
  localparam int SRC_MSB           = 5;
  localparam int SRC_LSB           = 4;
  localparam int PRE_MSB           = 3;
  localparam int PRE_LSB           = 0;
  // ==========================================================================
  // Reset values and encodings
  localparam logic [1:0] SRC_BUS_CLOCK  = 2'h0;
  localparam logic [1:0] SRC_FIXED_FREQ = 2'h1;
  localparam logic [1:0] SRC_EXT_FALL   = 2'h2;
  localparam logic [1:0] SRC_EXT_RISE   = 2'h3;
  localparam logic [3:0] PRE_RESET      = 4'h0;
  localparam logic [3:0] PRE_MAX_CODE   = 4'h8;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] WRAP_RESET     = 8'h00;
  localparam logic       HALT_RESET     = 1'b1;
  localparam int         PRE_WIDTH      = 8;
endpackage

// ### src/mt_tick_if.sv
// Interface carrying the prescaler setting and the resulting count tick.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface mt_tick_if;
  logic       src_tick;
  logic       run;
  logic       clear;
  logic [3:0] prescale_select;
  logic       count_tick;
  modport ctrl (output src_tick, output run, output clear, output prescale_select,
                input count_tick);
  modport pre  (input src_tick, input run, input clear, input prescale_select,
                output count_tick);
endinterface
`default_nettype wire

// ### src/mt_prescaler.sv
// Prescaler: divides source ticks by a power of two selected by a code.
// Assumes source ticks are one-cycle pulses in the system clock domain.
`timescale 1ns/100ps
`default_nettype none
module mt_prescaler #(
  parameter int WIDTH = mt_pkg::PRE_WIDTH
) (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_ce,
  mt_tick_if.pre    tick
);
  typedef struct packed {
    logic [WIDTH-1:0] div_cnt;
    logic             out_tick;
  } mt_pre_state_type;

  mt_pre_state_type state_reg;
  mt_pre_state_type state_next;
  logic [3:0]       code;
  logic [WIDTH-1:0] mask;

  // ==========================================================================
  // Divider
  // Changing the code keeps the divider phase; only clear or a completed division zeroes the count.
  always_comb begin
    code = (tick.prescale_select > mt_pkg::PRE_MAX_CODE) ? mt_pkg::PRE_MAX_CODE
         : tick.prescale_select;
    mask = WIDTH'((9'h001 << code) - 9'h001);
    state_next = state_reg;
    state_next.out_tick = 1'b0;
    if (tick.clear) begin
      state_next.div_cnt = '0;
    end else if (tick.run && tick.src_tick) begin
      if ((state_reg.div_cnt & mask) == mask) begin
        state_next.div_cnt  = '0;
        state_next.out_tick = 1'b1;
      end else begin
        state_next.div_cnt = state_reg.div_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign tick.count_tick = state_reg.out_tick;
endmodule
`default_nettype wire

// ### src/mt_modulo_timer.sv
// Top of the 8-bit modulo timer with an APB register slave.
// Assumes all inputs, the external pin included, are synchronous to i_clk_sys.
// ============================================================================
// How it works
// - Overflow flag sets when counter wraps from the wrap value to zero.
// - Flag clears by status read while set, then writing zero to bit 7.
// - Interrupt request asserts when enable bit 6 and flag are both set.
// - Writing one to bit 5 zeroes counter and flag; reads as zero.
// - Halt bit 4 freezes the counter; reset sets it.
// - Source field 5:4 picks bus, fixed clock, pin falling or rising edge.
// - Changing source keeps the present count.
// - Prescale field 3:0 divides by one, two, four, up to 256.
// - Codes above eight divide by 256.
// - Changing prescale keeps the present count.
// - Reset selects the bus clock undivided.
// - Count register is read-only and resets to zero.
// - Wrap value zero gives a free-running counter.
// - Any write to the wrap register zeroes counter and flag.
// - Reset loads zero into the wrap register.
// - Counter increments per tick until equal to wrap value, then wraps.
// - An overflow between read and clearing write keeps the flag set.
// - Counting is suspended during debug mode and resumes afterwards.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module mt_modulo_timer (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  input  wire logic        i_fixed_freq_clock,
  input  wire logic        i_ext_timer_clock_pin,
  input  wire logic        i_debug_active,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  output logic             o_timer_irq
);
  typedef struct packed {
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic        counter_halt;
    logic        clear_armed;
    logic [1:0]  source_select;
    logic [3:0]  prescale_select;
    logic [7:0]  count;
    logic [7:0]  wrap_value;
    logic        fixed_prev;
    logic        pin_prev;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
  } mt_state_type;

  mt_state_type state_reg;
  mt_state_type state_next;
  mt_tick_if    tick ();
  logic         setup;
  logic         wr;
  logic         rd;
  logic [3:0]   addr;
  logic         hit;
  logic         src_tick;
  logic         wrap_hit;
  logic         reset_count;

  // ==========================================================================
  // Prescaler
  mt_prescaler #(
    .WIDTH (mt_pkg::PRE_WIDTH)
  ) u_prescaler (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .tick      (tick.pre)
  );

  // ==========================================================================
  // Source selection
  // The pin must toggle no faster than half the bus clock to be seen.
  always_comb begin
    case (state_reg.source_select)
      mt_pkg::SRC_BUS_CLOCK:  src_tick = 1'b1;
      mt_pkg::SRC_FIXED_FREQ: src_tick = i_fixed_freq_clock & ~state_reg.fixed_prev;
      mt_pkg::SRC_EXT_FALL:   src_tick = ~i_ext_timer_clock_pin & state_reg.pin_prev;
      default:                src_tick = i_ext_timer_clock_pin & ~state_reg.pin_prev;
    endcase
  end

  // ==========================================================================
  // Bus decode
  // Answers in the first access cycle, so no wait states are inserted.
  always_comb begin
    setup = i_psel & ~i_penable;
    wr    = setup & i_pwrite & i_pstrb[0];
    rd    = setup & ~i_pwrite;
    addr  = i_paddr[3:0];
    hit   = (i_paddr[11:4] == 8'h00) && (addr[1:0] == 2'h0);
    reset_count = 1'b0;
    if (wr && hit && addr == mt_pkg::OFS_STATUS_CONTROL) begin
      reset_count = i_pwdata[mt_pkg::BIT_COUNTER_RESET];
    end else if (wr && hit && addr == mt_pkg::OFS_WRAP_LIMIT) begin
      reset_count = 1'b1;
    end
  end

  assign tick.src_tick        = src_tick;
  assign tick.run             = ~state_reg.counter_halt & ~i_debug_active;
  assign tick.clear           = reset_count;
  assign tick.prescale_select = state_reg.prescale_select;

  // ==========================================================================
  // Counter, registers and bus answer
  always_comb begin
    state_next            = state_reg;
    state_next.fixed_prev = i_fixed_freq_clock;
    state_next.pin_prev   = i_ext_timer_clock_pin;
    state_next.pready     = setup;
    state_next.pslverr    = setup & ~hit;
    state_next.prdata     = 32'h0000_0000;
    // A wrap value of zero must not match a count of zero, or the counter would stick there.
    wrap_hit = (state_reg.count == ((state_reg.wrap_value == 8'h00) ? 8'hff
                                                                    : state_reg.wrap_value));
    if (rd && hit) begin
      if (addr == mt_pkg::OFS_STATUS_CONTROL) begin
        state_next.prdata[mt_pkg::BIT_OVERFLOW_FLAG] = state_reg.overflow_flag;
        state_next.prdata[mt_pkg::BIT_IRQ_ENABLE]    = state_reg.overflow_irq_enable;
        state_next.prdata[mt_pkg::BIT_COUNTER_HALT]  = state_reg.counter_halt;
        state_next.clear_armed = state_reg.overflow_flag;
      end else if (addr == mt_pkg::OFS_CLOCK_CONFIG) begin
        state_next.prdata[mt_pkg::SRC_MSB:mt_pkg::SRC_LSB] = state_reg.source_select;
        state_next.prdata[mt_pkg::PRE_MSB:mt_pkg::PRE_LSB] = state_reg.prescale_select;
      end else if (addr == mt_pkg::OFS_COUNT_VALUE) begin
        state_next.prdata[7:0] = state_reg.count;
      end else begin
        state_next.prdata[7:0] = state_reg.wrap_value;
      end
    end
    if (wr && hit) begin
      if (addr == mt_pkg::OFS_STATUS_CONTROL) begin
        state_next.overflow_irq_enable = i_pwdata[mt_pkg::BIT_IRQ_ENABLE];
        state_next.counter_halt        = i_pwdata[mt_pkg::BIT_COUNTER_HALT];
        if (!i_pwdata[mt_pkg::BIT_OVERFLOW_FLAG] && state_reg.clear_armed) begin
          state_next.overflow_flag = 1'b0;
        end
        state_next.clear_armed = 1'b0;
      end else if (addr == mt_pkg::OFS_CLOCK_CONFIG) begin
        state_next.source_select   = i_pwdata[mt_pkg::SRC_MSB:mt_pkg::SRC_LSB];
        state_next.prescale_select = i_pwdata[mt_pkg::PRE_MSB:mt_pkg::PRE_LSB];
      end else if (addr == mt_pkg::OFS_WRAP_LIMIT) begin
        state_next.wrap_value = i_pwdata[7:0];
      end
    end
    if (reset_count) begin
      state_next.count         = mt_pkg::COUNT_RESET;
      state_next.overflow_flag = 1'b0;
      state_next.clear_armed   = 1'b0;
    end else if (tick.count_tick) begin
      if (wrap_hit) begin
        // A wrap disarms the two-step clear, so a pending clear cannot lose it.
        state_next.count         = mt_pkg::COUNT_RESET;
        state_next.overflow_flag = 1'b1;
        state_next.clear_armed   = 1'b0;
      end else begin
        state_next.count = state_reg.count + 8'h01;
      end
    end
    state_next.irq = state_next.overflow_flag & state_next.overflow_irq_enable;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg                 <= '0;
      state_reg.counter_halt    <= mt_pkg::HALT_RESET;
      state_reg.source_select   <= mt_pkg::SRC_BUS_CLOCK;
      state_reg.prescale_select <= mt_pkg::PRE_RESET;
      state_reg.count           <= mt_pkg::COUNT_RESET;
      state_reg.wrap_value      <= mt_pkg::WRAP_RESET;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign o_pready    = state_reg.pready;
  assign o_prdata    = state_reg.prdata;
  assign o_pslverr   = state_reg.pslverr;
  assign o_timer_irq = state_reg.irq;
endmodule
`default_nettype wire

// ### tb/mt_modulo_timer_assertions.sv
// Checker for the modulo timer top: APB answer timing and register read fields.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module mt_modulo_timer_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  input wire logic        i_ce,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        o_timer_irq
);
  // ==========================================================================
  // Address of the pending setup, so the answer cycle knows what it answers.
  logic [11:0] addr_q;
  always_ff @(posedge i_clk_sys) begin
    addr_q <= i_paddr;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  sequence s_setup;
    i_psel && !i_penable && i_ce;
  endsequence
  sequence s_status_read;
    i_psel && !i_penable && i_ce && !i_pwrite && i_paddr == 12'h0 ##1 o_pready;
  endsequence
  sequence s_clock_read;
    i_psel && !i_penable && i_ce && !i_pwrite && i_paddr == 12'h4 ##1 o_pready;
  endsequence
  // ==========================================================================
  // Properties
  chk_ready_after_setup: assert property (s_setup |=> o_pready)
    else $error("no answer one cycle after setup");
  chk_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  chk_idle_quiet: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr)
    else $error("read data or error outside an answer");
  chk_unmapped_error: assert property (s_setup ##1 o_pready |->
    o_pslverr == (addr_q[11:4] != 8'h0 || addr_q[1:0] != 2'h0))
    else $error("error response does not match address");
  chk_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_status_unused: assert property (s_status_read |->
    o_prdata[5:0] == 6'h0 || o_prdata[5:0] == 6'h10)
    else $error("status unused or reset bit reads one");
  chk_clock_unused: assert property (s_clock_read |-> o_prdata[7:6] == 2'h0)
    else $error("clock config upper bits read one");
  chk_irq_matches: assert property (s_status_read |->
    $past(o_timer_irq) == (o_prdata[7] && o_prdata[6]))
    else $error("interrupt differs from flag and enable");
  chk_reset_quiet: assert property ($fell(i_srst) |-> !o_timer_irq && !o_pready)
    else $error("outputs active after reset");
endmodule
bind mt_modulo_timer mt_modulo_timer_chk u_chk (.i_clk_sys, .i_srst, .i_ce, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .o_pready, .o_prdata, .o_pslverr, .o_timer_irq);
`default_nettype wire

// ### tb/mt_modulo_timer_tb.sv
// Testbench for the modulo timer: APB register tests with expected values.
// Assumes an APB slave; the master waits for pready, so slave wait states are tolerated.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module mt_modulo_timer_tb;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, ffc = 0, pin = 0, dbg = 0;
  logic        pready, pslverr, irq, e, ce = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, q1;
  int          bad_count = 0, checks = 0, cnt = 0;
  logic [7:0]  cfgs [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h0f, 8'h10, 8'h20, 8'h30};
  int          cycs [9] = '{14, 30, 62, 126, 2046, 2046, 62, 62, 62};
  int          exs  [9] = '{16, 16, 16, 16, 8, 8, 16, 8, 8};
  initial forever #12.5 clk = ~clk;
  // Fixed clock rises every 4 cycles, the pin falls and rises every 8.
  always @(posedge clk) begin
    cnt <= cnt + 1;
    ffc <= cnt[1];
    pin <= cnt[2];
  end
  mt_modulo_timer dut (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hf), .i_fixed_freq_clock(ffc), .i_ext_timer_clock_pin(pin),
    .i_debug_active(dbg), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .o_timer_irq(irq));
  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    // Called just after a rising edge; returns just after one, so calls never collide.
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, q)
  endtask
  task automatic span(input logic [7:0] cfg, input int cyc, input int ex);
    wr(12'h4, {24'h0, cfg});
    wr(12'h0, 32'h30);
    wr(12'h0, 32'h0);
    repeat (cyc) @(posedge clk);
    wr(12'h0, 32'h10);
    apb(1'b0, 12'h8, 32'h0);
    `CHK("count in range", 1'b1, (q >= ex - 2) && (q <= ex + 2))
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(12'h0, 32'h10, "status reset");
    rd(12'h4, 32'h0, "clock reset");
    rd(12'hc, 32'h0, "wrap reset");
    wr(12'h8, 32'h55);
    rd(12'h8, 32'h0, "count value");
    rd(12'h10, 32'h0, "unmapped data");
    `CHK("unmapped error", 1'b1, e)
    $display("test reset_map done");
    wr(12'hc, 32'h3);
    wr(12'h0, 32'h0);
    repeat (20) @(posedge clk);
    wr(12'h0, 32'h10);
    apb(1'b0, 12'h8, 32'h0);
    `CHK("count bound", 1'b1, q <= 32'h3)
    rd(12'h8, q, "halted count");
    rd(12'h0, 32'h90, "flag set");
    wr(12'h0, 32'h90);
    wr(12'h0, 32'h10);
    rd(12'h0, 32'h90, "flag kept");
    wr(12'h0, 32'h10);
    rd(12'h0, 32'h10, "flag cleared");
    $display("test flag done");
    wr(12'h0, 32'h40);
    repeat (20) @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    wr(12'h0, 32'h10);
    @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    rd(12'h0, 32'h90, "masked flag");
    wr(12'h0, 32'h30);
    rd(12'h0, 32'h10, "reset bit");
    rd(12'h8, 32'h0, "count reset bit");
    wr(12'h0, 32'h0);
    repeat (20) @(posedge clk);
    wr(12'h0, 32'h10);
    wr(12'hc, 32'h0);
    rd(12'h0, 32'h10, "wrap write flag");
    rd(12'h8, 32'h0, "wrap write count");
    $display("test irq_clear done");
    wr(12'h0, 32'h0);
    dbg <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h8, 32'h0);
    repeat (10) @(posedge clk);
    rd(12'h8, q, "debug hold");
    dbg <= 1'b0;
    // Clock enable low must freeze the running counter; a free count would move by about 40.
    apb(1'b0, 12'h8, 32'h0);
    q1 = q;
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    apb(1'b0, 12'h8, 32'h0);
    `CHK("clock enable hold", 1'b1, (q - q1) <= 32'h5)
    $display("test debug done");
    wr(12'h0, 32'h30);
    wr(12'h0, 32'h0);
    repeat (20) @(posedge clk);
    wr(12'h4, 32'h08);
    wr(12'h4, 32'h18);
    wr(12'h0, 32'h10);
    apb(1'b0, 12'h8, 32'h0);
    `CHK("count kept", 1'b1, (q >= 32'd21) && (q <= 32'd25))
    $display("test live change done");
    for (int i = 0; i < 9; i++) span(cfgs[i], cycs[i], exs[i]);
    $display("test sources done");
    wr(12'hc, 32'h5);
    wr(12'h0, 32'h40);
    repeat (60) @(posedge clk);
    `CHK("irq before reset", 1'b1, irq)
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(12'h0, 32'h10, "reset irq enable");
    rd(12'h4, 32'h0, "reset source");
    rd(12'hc, 32'h0, "reset wrap");
    rd(12'h8, 32'h0, "reset count");
    $display("test mid reset done");
    print_verdict();
  end
  // The longest legal run is about 5000 cycles; this bound only catches a hang.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
